// [hw/wdtts_map.vh]
// register offsets, field positions, reset values, unlock key and ID constants
`ifndef WDTTS_MAP_VH
`define WDTTS_MAP_VH

`define WDTTS_AW            4
`define WDTTS_DW            32

`define WDTTS_OFF_LOAD      4'h0
`define WDTTS_OFF_VALUE     4'h1
`define WDTTS_OFF_CTRL      4'h2
`define WDTTS_OFF_ICLR      4'h3
`define WDTTS_OFF_RIS       4'h4
`define WDTTS_OFF_MIS       4'h5
`define WDTTS_OFF_LOCK      4'h6
`define WDTTS_OFF_STATUS    4'h7
`define WDTTS_OFF_MASK      4'h8
`define WDTTS_OFF_ID        4'h9

`define WDTTS_CTRL_INTEN    0
`define WDTTS_CTRL_RESEN    1
`define WDTTS_CTRL_NMI      2
`define WDTTS_CTRL_STALL    3

`define WDTTS_EV_TIMEOUT    0
`define WDTTS_EV_RESET      1
`define WDTTS_EV_W          2

`define WDTTS_UNLOCK_KEY    32'h1ACCE551
`define WDTTS_LOAD_RST      32'hFFFFFFFF
`define WDTTS_ZERO32        32'h00000000
`define WDTTS_ONE32         32'h00000001
`define WDTTS_ID_VALUE      32'h0000A5C3

`endif

// [hw/wdtts_down_counter.v]
// 32-bit down counter with load, hold at zero and expiry flag
`include "wdtts_map.vh"
`default_nettype none

module wdtts_down_counter (
    input  wire        clk_in,
    input  wire        resetn_in,
    input  wire        load_in,
    input  wire [31:0] load_value_in,
    input  wire        run_in,
    output reg  [31:0] count_out,
    output wire        zero_out
);

    assign zero_out = (count_out == `WDTTS_ZERO32);

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_out <= `WDTTS_LOAD_RST;
        end else if (load_in) begin
            count_out <= load_value_in;
        end else if (run_in && !zero_out) begin
            count_out <= count_out - `WDTTS_ONE32;
        end
    end

endmodule

`default_nettype wire

// [hw/wdtts_top.v]
// two-stage watchdog timer with register port and interrupt logic
//
// Notes on behaviour
// - a 32-bit counter counts down from the programmable load value
// - locked state ignores load, control and interrupt clear writes
// - first zero after enable raises the timeout interrupt
// - one enable bit starts counting and interrupt generation together
// - first timeout reloads the counter and counting goes on
// - second zero with interrupt pending and reset enabled asserts reset
// - clearing interrupt before second expiry reloads counter and resumes
// - load write while running places value in counter at once
// - optional non-maskable output, same enable, held until cleared
// - interrupt clear removes the source so the output falls
// - enable commands are ignored while locked
// - raw and masked timeout status are both readable
// - a load value of zero written while running raises the interrupt at once
// - lock engagement is readable
// - debug stall option halts counting while processor is halted
`include "wdtts_map.vh"
`default_nettype none

module wdtts_top (
    input  wire        core_clk_in,
    input  wire        resetn_in,
    input  wire [3:0]  addr_in,
    input  wire [31:0] wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    input  wire        cpu_halted_in,
    output reg  [31:0] rdata_out,
    output reg  [31:0] count_out,
    output reg         wdt_int_out,
    output reg         wdt_nmi_out,
    output reg         sys_reset_out,
    output reg         irq_out
);

    parameter [31:0] ID_VALUE = `WDTTS_ID_VALUE; // arbitrary value

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [31:0]            load_r;
    reg                    run_r;
    reg                    resen_r;
    reg                    nmi_r;
    reg                    stall_r;
    reg                    lock_r;
    reg                    ris_r;
    reg                    reset_r;
    reg  [`WDTTS_EV_W-1:0] status_r;
    reg  [`WDTTS_EV_W-1:0] mask_r;
    reg  [31:0]            rdata_nxt;

    wire [31:0] cnt;
    wire        cnt_zero;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    function hit;
        input [3:0] a;
        input [3:0] off;
        begin
            hit = wr_in && (a == off);
        end
    endfunction

    wire wr_load = hit(addr_in, `WDTTS_OFF_LOAD) && !lock_r;
    wire wr_ctrl = hit(addr_in, `WDTTS_OFF_CTRL) && !lock_r;
    wire wr_iclr = hit(addr_in, `WDTTS_OFF_ICLR) && !lock_r;
    wire wr_lock = hit(addr_in, `WDTTS_OFF_LOCK);
    wire wr_stat = hit(addr_in, `WDTTS_OFF_STATUS);
    wire wr_mask = hit(addr_in, `WDTTS_OFF_MASK);

    // ----------------------------------------
    // counter control
    // ----------------------------------------
    wire counting = run_r && !(stall_r && cpu_halted_in);
    wire expire   = counting && cnt_zero;
    wire first_to = expire && !ris_r;
    wire second_to = expire && ris_r;
    // first enable starts the count from the load value
    wire go_load  = wr_ctrl && wdata_in[`WDTTS_CTRL_INTEN] && !run_r;
    // load on first enable, expiry, clear, load write while running
    wire do_load  = expire || wr_iclr || go_load ||
                    (wr_load && run_r);

    wire [31:0] load_src = wr_load ? wdata_in : load_r;

    wdtts_down_counter u_cnt (
        .clk_in        (core_clk_in),
        .resetn_in     (resetn_in),
        .load_in       (do_load),
        .load_value_in (load_src),
        .run_in        (counting),
        .count_out     (cnt),
        .zero_out      (cnt_zero)
    );

    // ----------------------------------------
    // configuration and status
    // ----------------------------------------
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            load_r   <= `WDTTS_LOAD_RST;
            run_r    <= 1'b0;
            resen_r  <= 1'b0;
            nmi_r    <= 1'b0;
            stall_r  <= 1'b0;
            lock_r   <= 1'b0;
            ris_r    <= 1'b0;
            reset_r  <= 1'b0;
            status_r <= {`WDTTS_EV_W{1'b0}};
            mask_r   <= {`WDTTS_EV_W{1'b0}};
        end else begin
            if (wr_load) begin
                load_r <= wdata_in;
            end
            if (wr_ctrl) begin
                // enable is sticky: only a reset clears run_r; a debug stall only pauses counting
                if (wdata_in[`WDTTS_CTRL_INTEN]) begin
                    run_r <= 1'b1;
                end
                resen_r <= wdata_in[`WDTTS_CTRL_RESEN];
                nmi_r   <= wdata_in[`WDTTS_CTRL_NMI];
                stall_r <= wdata_in[`WDTTS_CTRL_STALL];
            end
            if (wr_lock) begin
                lock_r <= (wdata_in != `WDTTS_UNLOCK_KEY);
            end
            // set wins over clear
            if (first_to || (wr_load && run_r &&
                    wdata_in == `WDTTS_ZERO32)) begin
                ris_r <= 1'b1;
            end else if (wr_iclr) begin
                ris_r <= 1'b0;
            end
            if (second_to && resen_r) begin
                reset_r <= 1'b1;
            end
            status_r <= (status_r & ~({`WDTTS_EV_W{wr_stat}} &
                        wdata_in[`WDTTS_EV_W-1:0])) |
                        {second_to && resen_r, first_to};
            if (wr_mask) begin
                mask_r <= wdata_in[`WDTTS_EV_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always @* begin
        rdata_nxt = `WDTTS_ZERO32;
        if (addr_in == `WDTTS_OFF_LOAD) begin
            rdata_nxt = load_r;
        end else if (addr_in == `WDTTS_OFF_VALUE) begin
            rdata_nxt = cnt;
        end else if (addr_in == `WDTTS_OFF_CTRL) begin
            rdata_nxt[`WDTTS_CTRL_INTEN] = run_r;
            rdata_nxt[`WDTTS_CTRL_RESEN] = resen_r;
            rdata_nxt[`WDTTS_CTRL_NMI]   = nmi_r;
            rdata_nxt[`WDTTS_CTRL_STALL] = stall_r;
        end else if (addr_in == `WDTTS_OFF_RIS) begin
            rdata_nxt[0] = ris_r;
        end else if (addr_in == `WDTTS_OFF_MIS) begin
            rdata_nxt[0] = ris_r && run_r;
        end else if (addr_in == `WDTTS_OFF_LOCK) begin
            rdata_nxt[0] = lock_r;
        end else if (addr_in == `WDTTS_OFF_STATUS) begin
            rdata_nxt[`WDTTS_EV_W-1:0] = status_r;
        end else if (addr_in == `WDTTS_OFF_MASK) begin
            rdata_nxt[`WDTTS_EV_W-1:0] = mask_r;
        end else if (addr_in == `WDTTS_OFF_ID) begin
            rdata_nxt = ID_VALUE;
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out     <= `WDTTS_ZERO32;
            count_out     <= `WDTTS_ZERO32;
            wdt_int_out   <= 1'b0;
            wdt_nmi_out   <= 1'b0;
            sys_reset_out <= 1'b0;
            irq_out       <= 1'b0;
        end else begin
            rdata_out     <= rd_in ? rdata_nxt : `WDTTS_ZERO32;
            count_out     <= cnt;
            wdt_int_out   <= ris_r && run_r && !nmi_r;
            wdt_nmi_out   <= ris_r && run_r && nmi_r;
            sys_reset_out <= reset_r;
            irq_out       <= |(status_r & mask_r);
        end
    end

endmodule

`default_nettype wire

// [sim/wdtts_chk.sv]
// port assertions for the two-stage watchdog
`default_nettype none
module wdtts_chk (
    input wire logic        core_clk_in,
    input wire logic        resetn_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [31:0] count_out,
    input wire logic        wdt_int_out,
    input wire logic        wdt_nmi_out,
    input wire logic        sys_reset_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!resetn_in);
    rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("stray read data");
    int_excl_a: assert property (!(wdt_int_out && wdt_nmi_out))
        else $error("both interrupts");
    cnt_step_a: assert property ($past(count_out) != 32'h0
        && !$past(wr_in) && !$past(wr_in, 2) |-> count_out == $past(count_out)
        || count_out == $past(count_out) - 32'h1) else $error("count jump");
    rst_keep_a: assert property (sys_reset_out |=> sys_reset_out)
        else $error("reset dropped");
    rst_cause_a: assert property ($rose(sys_reset_out)
        |-> $past(wdt_int_out || wdt_nmi_out)) else $error("early reset");
    int_zero_a: assert property ($rose(wdt_int_out || wdt_nmi_out)
        |-> count_out == 32'h0 || $past(count_out) == 32'h0)
        else $error("interrupt without expiry");
    int_hold_a: assert property (wdt_int_out && !wr_in && !$past(wr_in)
        |=> wdt_int_out) else $error("interrupt dropped");
    nmi_hold_a: assert property (wdt_nmi_out && !wr_in && !$past(wr_in)
        |=> wdt_nmi_out) else $error("nmi dropped");
    cover property ($rose(sys_reset_out));
    cover property ($rose(wdt_nmi_out));
    cover property ($fell(wdt_int_out));
endmodule
bind wdtts_top wdtts_chk chk_u (.core_clk_in, .resetn_in, .wr_in, .rd_in,
    .rdata_out, .count_out, .wdt_int_out, .wdt_nmi_out, .sys_reset_out);
`default_nettype wire

// [sim/wdtts_host.sv]
// system reset logic model: counts reset requests
`default_nettype none
module wdtts_host (
    input  wire logic core_clk_in,
    input  wire logic resetn_in,
    input  wire logic reset_req_in,
    output var  int   resets_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic req_r;
    always @(posedge core_clk_in or negedge resetn_in) begin
        req_r <= resetn_in && reset_req_in;
        resets_out <= resetn_in ? resets_out + (reset_req_in && !req_r) : 0;
    end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the two-stage watchdog
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic W = 1'h1;
    localparam logic R = 1'h0;
    logic        core_clk_in, resetn_in, wr_in, rd_in, cpu_halted_in;
    logic        wdt_int_out, wdt_nmi_out, sys_reset_out, irq_out;
    logic [3:0]  addr_in;
    logic [31:0] wdata_in, rdata_out, count_out;
    int          fails, num_checks, resets;
    wire  [3:0]  outs = {sys_reset_out, wdt_nmi_out, wdt_int_out, irq_out};
    wdtts_top dut_u (.core_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .cpu_halted_in, .rdata_out, .count_out, .wdt_int_out,
        .wdt_nmi_out, .sys_reset_out, .irq_out);
    wdtts_host host_u (.core_clk_in, .resetn_in,
        .reset_req_in(sys_reset_out), .resets_out(resets));
    initial begin
        core_clk_in = 1'h0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic w, logic [3:0] a, logic [31:0] d = 32'h0);
        {addr_in, wdata_in, wr_in, rd_in} <= {a, d, w, !w};
        @(posedge core_clk_in);
        {wr_in, rd_in} <= 2'h0;
        @(posedge core_clk_in);
    endtask
    task automatic wait_hi(input int s, input int lim);
        for (int n = 0; n < lim && outs[s] !== 1'h1; n++)
            @(posedge core_clk_in);
    endtask
    task automatic do_reset();
        resetn_in <= 1'h0;
        repeat (2) @(posedge core_clk_in);
        resetn_in <= 1'h1;
        @(posedge core_clk_in);
    endtask
    task automatic t_lock();
        acc(W, 4'h6);
        acc(R, 4'h6);
        chk("lock", 32'h1, rdata_out);
        acc(W, 4'h0, 32'h7);
        acc(W, 4'h2, 32'h1);
        acc(R, 4'h0);
        chk("load", 32'hFFFFFFFF, rdata_out);
        acc(R, 4'h1);
        chk("value", 32'hFFFFFFFF, rdata_out);
        acc(W, 4'h6, 32'h1ACCE551);
        acc(R, 4'hF);
        chk("unmapped", 32'h0, rdata_out);
        $display("lock test done");
    endtask
    task automatic t_first();
        acc(W, 4'h8, 32'h1);
        acc(W, 4'h0, 32'h14);
        acc(W, 4'h2, 32'h1);
        wait_hi(1, 60);
        chk("int", 32'h1, wdt_int_out);
        acc(R, 4'h5);
        chk("masked", 32'h1, rdata_out);
        chk("irq", 32'h1, irq_out);
        acc(W, 4'h3);
        acc(W, 4'h7, 32'h1);
        repeat (2) @(posedge core_clk_in);
        chk("cleared", 32'h0, {irq_out, wdt_int_out});
        chk("reload", 32'h1, count_out > 32'hE);
        acc(W, 4'h2, 32'h3);
        wait_hi(3, 60);
        @(posedge core_clk_in);
        chk("resets", 32'h1, resets);
        $display("timeout test done");
    endtask
    task automatic t_nmi();
        logic [31:0] held;
        acc(W, 4'h2, 32'hD);
        acc(W, 4'h0, 32'h64);
        repeat (2) @(posedge core_clk_in);
        chk("count", 32'h1, count_out > 32'h5A && count_out <= 32'h64);
        cpu_halted_in <= 1'h1;
        repeat (2) @(posedge core_clk_in);
        held = count_out;
        repeat (3) @(posedge core_clk_in);
        chk("stall", held, count_out);
        cpu_halted_in <= 1'h0;
        acc(W, 4'h0);
        wait_hi(2, 4);
        chk("nmi", 32'h1, {irq_out, wdt_int_out, wdt_nmi_out});
        $display("nmi test done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        {resetn_in, wr_in, rd_in, addr_in, wdata_in, cpu_halted_in} = '0;
        do_reset();
        t_lock();
        t_first();
        do_reset();
        t_nmi();
        give_verdict();
    end
    initial begin
        #20us;
        fails++;
        give_verdict();
    end
endmodule
`default_nettype wire
